// File: inc/cct_pkg.sv
package cct_pkg;

   // ***************************************
   // widths and sizes
   // ***************************************
   localparam int unsigned NCH      = 4;
   localparam int unsigned DT_W     = 8;
   localparam logic [31:0] MAX_STD  = 32'h0000FFFF;
   localparam logic [31:0] MAX_WIDE = 32'hFFFFFFFF;

   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_TOP     = 8'h04;
   localparam logic [7:0] A_CNT     = 8'h08;
   localparam logic [7:0] A_STAT    = 8'h0C;
   localparam logic [7:0] A_DEAD    = 8'h10;
   localparam logic [7:0] A_CH_BASE = 8'h20;
   localparam logic [7:0] A_CH_END  = 8'h3F;
   localparam int unsigned B_RUN    = 0;
   localparam int unsigned B_EVCNT  = 1;
   localparam int unsigned B_OVF    = 0;
   localparam int unsigned B_HIT0   = 1;
   localparam logic [1:0]  RST_CTRL = 2'h0;
   localparam logic [7:0]  RST_DEAD = 8'h00;

   typedef enum logic [1:0] {CCT_OFF, CCT_CAPTURE, CCT_COMPARE, CCT_PWM} cct_mode_t;

   typedef struct packed {
      cct_mode_t   mode;
      logic [31:0] val;
      logic        val_wr;
   } cct_chan_ctl_t;

   typedef struct packed {
      logic           overflow;
      logic [NCH-1:0] hit;
   } cct_evt_t;

endpackage : cct_pkg

// File: src/cct_chan.sv
`timescale 1ns/10ps
`default_nettype none
module cct_chan (
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   input  wire cct_pkg::cct_chan_ctl_t ctl,
   input  wire logic [31:0]          cnt,
   input  wire logic                 tick,
   input  wire logic                 wrap,
   input  wire logic                 cap_ev,
   input  wire logic                 dt_en,
   input  wire logic [7:0]           dt_len,
   output logic [31:0]               val_rd,
   output logic                      hit,
   output logic                      out_pos,
   output logic                      out_neg
);

   typedef struct packed {
      logic [31:0] cmp;
      logic [31:0] shadow;
      logic [31:0] capv;
      logic        lvl;
      logic [7:0]  dt;
      logic        pos;
      logic        neg;
      logic        hit;
   } cct_chan_state_t;

   cct_chan_state_t st;
   cct_chan_state_t next_st;
   logic            active;

   always_comb begin
      next_st     = st;
      next_st.hit = 1'b0;
      active      = (ctl.mode == cct_pkg::CCT_COMPARE) || (ctl.mode == cct_pkg::CCT_PWM);
      if (ctl.val_wr) begin
         next_st.shadow = ctl.val;
         if (ctl.mode != cct_pkg::CCT_PWM) begin
            next_st.cmp = ctl.val;
         end
      end
      case (ctl.mode)
         cct_pkg::CCT_CAPTURE: begin
            next_st.lvl = 1'b0;
            if (cap_ev) begin
               next_st.capv = cnt;
               next_st.hit  = 1'b1;
            end
         end
         cct_pkg::CCT_COMPARE: begin
            next_st.lvl = (cnt >= st.cmp);
            next_st.hit = tick && (cnt == st.cmp);
         end
         // pwm takes next value at wrap
         cct_pkg::CCT_PWM: begin
            if (wrap) begin
               next_st.cmp = st.shadow;
            end
            next_st.lvl = (cnt < st.cmp);
            next_st.hit = tick && (cnt == st.cmp);
         end
         default: begin
            next_st.lvl = 1'b0;
         end
      endcase
      if (active && dt_en && (dt_len != 8'h00) && (next_st.lvl != st.lvl)) begin
         next_st.dt  = dt_len;
         next_st.pos = 1'b0;
         next_st.neg = 1'b0;
      end else if (st.dt > 8'h01) begin
         next_st.dt  = st.dt - 8'h01;
         next_st.pos = 1'b0;
         next_st.neg = 1'b0;
      end else begin
         next_st.dt  = 8'h00;
         next_st.pos = active && next_st.lvl;
         next_st.neg = active && dt_en && !next_st.lvl;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign val_rd  = (ctl.mode == cct_pkg::CCT_CAPTURE) ? st.capv : st.shadow;
   assign hit     = st.hit;
   assign out_pos = st.pos;
   assign out_neg = st.neg;

   // ***************************************
   // assertions
   // ***************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_capture_value: assert property (
      (ctl.mode == cct_pkg::CCT_CAPTURE) && cap_ev |=> (st.capv == $past(cnt)) && hit)
      else $error("capture did not store counter");
   a_compare_level: assert property (
      (ctl.mode == cct_pkg::CCT_COMPARE) && $stable(ctl.mode) && (!dt_en || (dt_len == 8'h00)) &&
      (st.dt <= 8'h01) |=> out_pos == ($past(cnt) >= $past(st.cmp)))
      else $error("compare output wrong");
   a_dead_gap_low: assert property (
      active && dt_en && (dt_len == 8'h02) && (next_st.lvl != st.lvl) |=> !out_pos && !out_neg ##1 !out_pos && !out_neg)
      else $error("dead time gap too short");
   a_no_overlap: assert property (
      !(out_pos && out_neg))
      else $error("both outputs high");
   c_capture: cover property ((ctl.mode == cct_pkg::CCT_CAPTURE) && cap_ev);
   c_pwm_reload: cover property ((ctl.mode == cct_pkg::CCT_PWM) && wrap);

endmodule : cct_chan
`default_nettype wire

// File: src/cct_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cct_timer #(
   parameter bit WIDE_VARIANT   = 1'b0,
   parameter bit FIRST_INSTANCE = 1'b1
) (
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata,
   input  wire logic                    count_event_in,
   input  wire logic [cct_pkg::NCH-1:0] capture_in,
   output logic [cct_pkg::NCH-1:0]      chan_out_pos,
   output logic [cct_pkg::NCH-1:0]      chan_out_neg,
   output cct_pkg::cct_evt_t            evt_out
);

   // ***************************************
   // state
   // ***************************************
   typedef struct packed {
      logic [1:0]                ctrl;
      logic [31:0]               top;
      logic [31:0]               cnt;
      logic [7:0]                dead;
      logic                      ovf;
      logic [cct_pkg::NCH-1:0]   flags;
      logic [2*cct_pkg::NCH-1:0] modes;
      logic [31:0]               rdata;
      logic                      ev_prev;
      logic [cct_pkg::NCH-1:0]   cap_prev;
      cct_pkg::cct_evt_t         evt;
   } cct_top_state_t;

   localparam logic [31:0] MAXV = WIDE_VARIANT ? cct_pkg::MAX_WIDE : cct_pkg::MAX_STD;
   // dead time only in first instance
   localparam bit HAS_DT = FIRST_INSTANCE;

   cct_top_state_t          st;
   cct_top_state_t          next_st;
   logic                    tick;
   logic                    wrap;
   logic [cct_pkg::NCH-1:0] cap_ev;
   logic [cct_pkg::NCH-1:0] hits;
   logic [31:0]             ch_val [cct_pkg::NCH];

   // channel register decode: bit 2 picks value over config
   function automatic logic ch_sel(input logic [7:0] a, input int unsigned n);
      ch_sel = (a >= cct_pkg::A_CH_BASE) && (a <= cct_pkg::A_CH_END) &&
               (a[1:0] == 2'h0) && (int'(a[4:3]) == n);
   endfunction : ch_sel

   // ***************************************
   // timebase
   // ***************************************
   // time or event counting
   assign tick   = st.ctrl[cct_pkg::B_RUN] &&
                   (!st.ctrl[cct_pkg::B_EVCNT] || (count_event_in && !st.ev_prev));
   assign wrap   = tick && (st.cnt == st.top);
   assign cap_ev = capture_in & ~st.cap_prev;

   // ***************************************
   // channels
   // ***************************************
   // four channels on one counter
   genvar gi;
   generate
      for (gi = 0; gi < cct_pkg::NCH; gi++) begin : g_ch
         cct_pkg::cct_chan_ctl_t ctl;
         always_comb begin
            ctl.mode   = cct_pkg::cct_mode_t'(st.modes[2*gi +: 2]);
            ctl.val    = reg_wdata & MAXV;
            ctl.val_wr = reg_wr && ch_sel(reg_addr, gi) && reg_addr[2];
         end
         cct_chan cct_chan_inst (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .ctl     (ctl),
            .cnt     (st.cnt),
            .tick    (tick),
            .wrap    (wrap),
            .cap_ev  (cap_ev[gi]),
            .dt_en   (HAS_DT),
            .dt_len  (st.dead),
            .val_rd  (ch_val[gi]),
            .hit     (hits[gi]),
            .out_pos (chan_out_pos[gi]),
            .out_neg (chan_out_neg[gi])
         );
      end
   endgenerate

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      next_st          = st;
      next_st.ev_prev  = count_event_in;
      next_st.cap_prev = capture_in;
      next_st.rdata    = 32'h00000000;
      if (tick) begin
         next_st.cnt = wrap ? 32'h00000000 : ((st.cnt + 32'h00000001) & MAXV);
      end
      if (reg_wr) begin
         case (reg_addr)
            cct_pkg::A_CTRL: next_st.ctrl = reg_wdata[1:0];
            cct_pkg::A_TOP:  next_st.top  = reg_wdata & MAXV;
            cct_pkg::A_CNT:  next_st.cnt  = reg_wdata & MAXV;
            cct_pkg::A_STAT: begin
               next_st.ovf   = st.ovf & ~reg_wdata[cct_pkg::B_OVF];
               next_st.flags = st.flags & ~reg_wdata[cct_pkg::B_HIT0 +: cct_pkg::NCH];
            end
            cct_pkg::A_DEAD: next_st.dead = HAS_DT ? reg_wdata[7:0] : 8'h00;
            default: begin
               for (int n = 0; n < cct_pkg::NCH; n++) begin
                  if (ch_sel(reg_addr, n) && !reg_addr[2]) begin
                     next_st.modes[2*n +: 2] = reg_wdata[1:0];
                  end
               end
            end
         endcase
      end
      if (wrap) begin
         next_st.ovf = 1'b1;
      end
      next_st.flags        = next_st.flags | hits;
      next_st.evt.overflow = wrap;
      next_st.evt.hit      = hits;
      if (reg_rd) begin
         case (reg_addr)
            cct_pkg::A_CTRL: next_st.rdata = {30'h00000000, st.ctrl};
            cct_pkg::A_TOP:  next_st.rdata = st.top;
            cct_pkg::A_CNT:  next_st.rdata = st.cnt;
            cct_pkg::A_STAT: next_st.rdata = {27'h0000000, st.flags, st.ovf};
            cct_pkg::A_DEAD: next_st.rdata = {24'h000000, st.dead};
            default: begin
               for (int n = 0; n < cct_pkg::NCH; n++) begin
                  if (ch_sel(reg_addr, n)) begin
                     next_st.rdata = reg_addr[2] ? ch_val[n] : {30'h00000000, st.modes[2*n +: 2]};
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st       <= '0;
         st.ctrl  <= cct_pkg::RST_CTRL;
         st.top   <= MAXV;
         st.dead  <= cct_pkg::RST_DEAD;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign evt_out   = st.evt;

   // ***************************************
   // assertions
   // ***************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_counter_wrap_zero: assert property (
      tick && (st.cnt == st.top) && !(reg_wr && (reg_addr == cct_pkg::A_CNT)) |=> (st.cnt == 32'h00000000) && st.ovf)
      else $error("counter did not wrap with overflow");
   a_counter_in_range: assert property (
      (st.cnt & ~MAXV) == 32'h00000000)
      else $error("counter exceeds variant width");
   a_overflow_set_wins: assert property (
      wrap && reg_wr && (reg_addr == cct_pkg::A_STAT) |=> st.ovf)
      else $error("overflow lost to clear");
   a_trigger_follows: assert property (
      wrap |=> evt_out.overflow ##1 !evt_out.overflow || $past(wrap))
      else $error("overflow trigger wrong");
   a_event_count_hold: assert property (
      st.ctrl[cct_pkg::B_EVCNT] && !(count_event_in && !st.ev_prev) && !reg_wr |=> $stable(st.cnt))
      else $error("counter moved without event");
   a_hit_flagged: assert property (
      |hits |=> ((st.flags & $past(hits)) == $past(hits)))
      else $error("channel hit not flagged");
   a_read_next_cycle: assert property (
      reg_rd && (reg_addr == cct_pkg::A_TOP) && !reg_wr |=> reg_rdata == $past(st.top))
      else $error("top read wrong");
   c_wrap: cover property (wrap);
   c_event_tick: cover property (tick && st.ctrl[cct_pkg::B_EVCNT]);
   c_all_hits: cover property (&st.flags);

endmodule : cct_timer
`default_nettype wire

// File: testbench/cct_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cct_far_model (
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   input  wire cct_pkg::cct_evt_t       evt,
   output logic                         count_event_in,
   output logic [cct_pkg::NCH-1:0]      capture_in
);
   int ovf_seen;
   int hit_seen;
   initial begin
      count_event_in = 1'b0;
      capture_in     = '0;
      ovf_seen       = 0;
      hit_seen       = 0;
   end
   // ***************************************
   // event network consumer
   // ***************************************
   // counts triggers
   always @(posedge ref_clk) begin
      if (resetn && evt.overflow === 1'b1) ovf_seen++;
      if (resetn && evt.hit[0] === 1'b1) hit_seen++;
   end
   task automatic pulse_cap(input int ch);
      @(posedge ref_clk) capture_in[ch] <= 1'b1;
      @(posedge ref_clk) capture_in[ch] <= 1'b0;
      @(posedge ref_clk);
   endtask : pulse_cap
   // count edges with a low gap
   task automatic pulse_ev(input int n);
      repeat (n) begin
         @(posedge ref_clk) count_event_in <= 1'b1;
         @(posedge ref_clk) count_event_in <= 1'b0;
         @(posedge ref_clk);
      end
   endtask : pulse_ev
endmodule : cct_far_model
`default_nettype wire

// File: testbench/tb_cct_timer.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t %h %h", $time, (a), (b)); end end
module tb_cct_timer;
   logic                    ref_clk = 1'b0;
   logic                    resetn = 1'b0;
   logic [7:0]              reg_addr = '0;
   logic [31:0]             reg_wdata = '0;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic [31:0]             reg_rdata;
   logic                    count_event_in;
   logic [cct_pkg::NCH-1:0] capture_in;
   logic [cct_pkg::NCH-1:0] chan_out_pos;
   logic [cct_pkg::NCH-1:0] chan_out_neg;
   cct_pkg::cct_evt_t       evt_out;
   logic [31:0]             wide_rdata;
   logic [cct_pkg::NCH-1:0] wide_pos;
   logic [cct_pkg::NCH-1:0] wide_neg;
   cct_pkg::cct_evt_t       wide_evt;
   int                      num_errors = 0;
   int                      samples_checked = 0;
   logic [31:0]             d;
   int                      n;

   always #25 ref_clk = ~ref_clk;

   cct_timer #(.WIDE_VARIANT(1'b0), .FIRST_INSTANCE(1'b1)) cct_timer_inst (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_event_in(count_event_in),
      .capture_in(capture_in), .chan_out_pos(chan_out_pos), .chan_out_neg(chan_out_neg),
      .evt_out(evt_out));
   cct_far_model cct_far_model_inst (
      .ref_clk(ref_clk), .resetn(resetn), .evt(evt_out),
      .count_event_in(count_event_in), .capture_in(capture_in));
   // wide variant without dead time, on the same bus and inputs
   cct_timer #(.WIDE_VARIANT(1'b1), .FIRST_INSTANCE(1'b0)) cct_timer_wide_inst (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(wide_rdata), .count_event_in(count_event_in),
      .capture_in(capture_in), .chan_out_pos(wide_pos), .chan_out_neg(wide_neg),
      .evt_out(wide_evt));

   // ***************************************
   // bus and helper tasks
   // ***************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk) begin
         reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      end
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk) begin
         reg_addr <= a; reg_rd <= 1'b1;
      end
      @(posedge ref_clk) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic finish_test;
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset;
      rd(cct_pkg::A_CTRL, d); `CHK(d, 32'h00000000)
      `CHK({chan_out_pos, chan_out_neg}, 8'h00)
      rd(cct_pkg::A_TOP, d);  `CHK(d, cct_pkg::MAX_STD)
      `CHK(wide_rdata, cct_pkg::MAX_WIDE)
      rd(cct_pkg::A_CNT, d);  `CHK(d, 32'h00000000)
      rd(cct_pkg::A_DEAD, d); `CHK(d, 32'h00000000)
      rd(8'hFC, d);           `CHK(d, 32'h00000000)
      wr(cct_pkg::A_CNT, 32'h00012345);
      rd(cct_pkg::A_CNT, d);  `CHK(d, 32'h00002345)
      `CHK(wide_rdata, 32'h00012345)
   endtask : t_reset
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         wr(cct_pkg::A_CH_BASE + 8'h18, m);
         rd(cct_pkg::A_CH_BASE + 8'h18, d); `CHK(d[1:0], m[1:0])
      end
   endtask : t_modes
   task automatic t_wrap;
      wr(cct_pkg::A_TOP, 32'h00000005);
      wr(cct_pkg::A_CNT, 32'h00000000);
      wr(cct_pkg::A_CTRL, 32'h00000001);
      for (n = 0; n < 40 && evt_out.overflow !== 1'b1; n++) cyc(1);
      n = 0;
      do begin cyc(1); n++; end while (n < 40 && evt_out.overflow !== 1'b1);
      `CHK(n, 6)
      `CHK(wide_evt.overflow, 1'b1)
      wr(cct_pkg::A_CTRL, 32'h00000000);
      rd(cct_pkg::A_STAT, d); `CHK(d[cct_pkg::B_OVF], 1'b1)
      wr(cct_pkg::A_STAT, 32'h0000001F);
      rd(cct_pkg::A_STAT, d); `CHK(d[4:0], 5'h00)
      `CHK(cct_far_model_inst.ovf_seen > 1, 1'b1)
   endtask : t_wrap
   task automatic t_capture;
      wr(cct_pkg::A_CNT, 32'h00000055);
      wr(cct_pkg::A_CH_BASE, 32'h00000001);
      cct_far_model_inst.pulse_cap(0);
      cyc(3);
      rd(cct_pkg::A_CH_BASE + 8'h04, d); `CHK(d, 32'h00000055)
      rd(cct_pkg::A_STAT, d); `CHK(d[cct_pkg::B_HIT0], 1'b1)
      `CHK(cct_far_model_inst.hit_seen, 1)
   endtask : t_capture
   task automatic t_events;
      wr(cct_pkg::A_TOP, cct_pkg::MAX_STD);
      wr(cct_pkg::A_CNT, 32'h00000000);
      wr(cct_pkg::A_CTRL, 32'h00000003);
      cct_far_model_inst.pulse_ev(3);
      rd(cct_pkg::A_CNT, d); `CHK(d, 32'h00000003)
      `CHK(wide_rdata, 32'h00000003)
      wr(cct_pkg::A_CTRL, 32'h00000000);
   endtask : t_events
   task automatic t_compare;
      wr(cct_pkg::A_CNT, 32'h00000010);
      wr(cct_pkg::A_CH_BASE + 8'h08, 32'h00000002);
      wr(cct_pkg::A_CH_BASE + 8'h0C, 32'h00000010);
      cyc(4); `CHK(chan_out_pos[1], 1'b1)
      `CHK(chan_out_neg[1], 1'b0)
      `CHK(wide_pos[1], 1'b1)
      wr(cct_pkg::A_CH_BASE + 8'h0C, 32'h00000011);
      cyc(4); `CHK(chan_out_pos[1], 1'b0)
      `CHK(chan_out_neg[1], 1'b1)
      `CHK(wide_neg[1], 1'b0)
   endtask : t_compare
   task automatic t_pwm;
      int hi;
      int gap;
      wr(cct_pkg::A_TOP, 32'h00000009);
      wr(cct_pkg::A_CNT, 32'h00000000);
      wr(cct_pkg::A_CH_BASE + 8'h10, 32'h00000003);
      wr(cct_pkg::A_CH_BASE + 8'h14, 32'h00000003);
      wr(cct_pkg::A_CTRL, 32'h00000001);
      cyc(30);
      hi = 0;
      for (int i = 0; i < 20; i++) begin cyc(1); hi += chan_out_pos[2]; end
      `CHK(hi, 6)
      wr(cct_pkg::A_DEAD, 32'h00000002);
      rd(cct_pkg::A_DEAD, d); `CHK(d, 32'h00000002)
      `CHK(wide_rdata, 32'h00000000)
      cyc(30);
      gap = 0;
      for (int i = 0; i < 20; i++) begin
         cyc(1); gap += (chan_out_pos[2] === 1'b0 && chan_out_neg[2] === 1'b0);
      end
      `CHK(gap, 8)
      rd(cct_pkg::A_STAT, d); `CHK(d[cct_pkg::B_HIT0 + 2], 1'b1)
   endtask : t_pwm

   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_modes();
      t_wrap();
      t_capture();
      t_events();
      t_compare();
      t_pwm();
      cyc(2);
      finish_test();
   end
   initial begin
      #2000000;
      num_errors++;
      finish_test();
   end
endmodule : tb_cct_timer
`default_nettype wire
